// [ati_target.sv]
// Two-wire bus target interface of the converter
`timescale 1ns/1ps
`include "ati_defines.svh"

// Notes on behaviour
// - Matching address gets SDA held low in the ack bit; mismatch leaves it released.
// - Every byte written after a matching address, pointer included, is acknowledged.
// - Start is SDA falling while SCL high; recognised, begins each transaction.
// - Repeated start is followed by address; speed mode stays as it was.
// - Stop is SDA rising while SCL high; bus idle until next start.
// - Start is followed by seven address bits, direction bit, then target ack.
// - First write byte after address is the pointer; stored and acknowledged.
// - Upper then lower byte follow the pointer, each acked; pairs may repeat.
// - Read address starts sending the upper byte of the pointed register.
// - One-byte read: controller nacks the first byte then stops.
// - Ack of upper sends lower; ack of lower sends next upper, repeating.
// - No limit on words streamed while the controller keeps acknowledging.
// - Master code after start enters high speed; target never acks it.
// - After master code a repeated start brings the address at high speed.
// - High speed lasts across repeated starts until a stop.
// - Unstrapped variant answers one fixed seven-bit address.
// - Strapped variant picks address from strap: float, ground or supply.
// - Zero is sent by pulling the line low; one by releasing it.
// - Pointer selects register for later accesses; reads reuse the last pointer.
module ati_target
  import ati_pkg::*;
#(
  parameter int STRAPPED = 0
)(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_link,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic [1:0]  addr_sel,
  output logic [7:0]       reg_ptr,
  output logic             wr_stb,
  output logic             wr_two,
  output logic [15:0]      wr_data,
  output logic             rd_stb,
  input  wire logic [15:0] rd_word,
  output logic             hs_mode
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  generate
    if (STRAPPED != 0 && STRAPPED != 1)
    begin : g_bad_strapped
      $error("STRAPPED must be 0 or 1");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Own address from strap code, or the fixed one
  function automatic logic [6:0] addr_of(input logic [1:0] strap);
    logic [6:0] a;
    a = `ATI_ADDR_FIXED;
    if (STRAPPED == 1)
    begin
      unique case (strap)
        `ATI_STRAP_GND:    a = `ATI_ADDR_GND;
        `ATI_STRAP_SUPPLY: a = `ATI_ADDR_SUPPLY;
        default:           a = `ATI_ADDR_FLOAT;
      endcase
    end
    return a;
  endfunction : addr_of

  // Put the upper byte of the fetched word on the line, or stretch
  function automatic ati_link_t load_upper(input ati_link_t s);
    ati_link_t r;
    r = s;
    if (s.word_ok)
    begin
      r.sh      = s.word[15:8];
      r.sda_drv = ~s.word[15];
      r.cnt     = '0;
      r.tx_hi   = 1'b1;
      r.st      = L_TX;
    end
    else
    begin
      r.st = L_WAIT;
    end
    return r;
  endfunction : load_upper

  ati_link_t l_q;
  ati_link_t l_d;
  ati_sys_t  s_q;
  ati_sys_t  s_d;
  logic      scl_rise;
  logic      scl_fall;
  logic      start_c;
  logic      stop_c;

  // --------------------------------------------------------------------------
  // Link domain: bus sampling and protocol engine
  // --------------------------------------------------------------------------

  // Conditions seen on the synchronised pins
  always_comb
  begin
    scl_rise = l_q.scl_s2 & ~l_q.scl_p;
    scl_fall = ~l_q.scl_s2 & l_q.scl_p;
    start_c  = l_q.scl_s2 & l_q.scl_p & l_q.sda_p & ~l_q.sda_s2;
    stop_c   = l_q.scl_s2 & l_q.scl_p & ~l_q.sda_p & l_q.sda_s2;
  end

  // Next link state
  always_comb
  begin
    l_d          = l_q;
    l_d.rst_s1   = resetn;
    l_d.rst_s2   = l_q.rst_s1;
    l_d.scl_s1   = scl_i;
    l_d.scl_s2   = l_q.scl_s1;
    l_d.scl_p    = l_q.scl_s2;
    l_d.sda_s1   = sda_i;
    l_d.sda_s2   = l_q.sda_s1;
    l_d.sda_p    = l_q.sda_s2;
    l_d.strap_s1 = addr_sel;
    l_d.strap_s2 = l_q.strap_s1;
    l_d.ak_s1    = s_q.ak_tgl;
    l_d.ak_s2    = l_q.ak_s1;
    l_d.ak_p     = l_q.ak_s2;

    // Word answer from the system side; held stable until the next request
    if (l_q.ak_s2 != l_q.ak_p)
    begin
      l_d.word    = s_q.rword;
      l_d.word_ok = 1'b1;
    end

    if (start_c || stop_c)
    begin
      // A lone upper byte is committed as a one-byte write
      if (l_q.half)
      begin
        l_d.ev     = '{wr: 1'b1, two: 1'b0, ptr: l_q.ptr, data: {l_q.upper, 8'h00}};
        l_d.ev_tgl = ~l_q.ev_tgl;
        l_d.half   = 1'b0;
      end
      l_d.sda_drv = 1'b0;
      l_d.cnt     = '0;
      l_d.st      = stop_c ? L_IDLE : L_ADDR;
      if (stop_c)
      begin
        l_d.hs = 1'b0;
      end
    end
    else
    begin
      unique case (l_q.st)
        L_IDLE, L_IGNORE:
        begin
          l_d.sda_drv = 1'b0;
        end
        L_ADDR, L_RX:
        begin
          if (scl_rise)
          begin
            l_d.sh  = {l_q.sh[6:0], l_q.sda_s2};
            l_d.cnt = l_q.cnt + 4'h1;
          end
          if (scl_fall && l_q.cnt == `ATI_BITS_DONE)
          begin
            l_d.cnt = '0;
            if (l_q.st == L_ADDR)
            begin
              if (l_q.sh[7:3] == `ATI_MCODE_TOP)
              begin
                l_d.hs = 1'b1;
                l_d.st = L_IGNORE;
              end
              else if (l_q.sh[7:1] == l_q.my_addr)
              begin
                l_d.sda_drv = 1'b1;
                l_d.st      = L_ACK;
                l_d.rw      = l_q.sh[0];
                l_d.idx     = `ATI_IDX_PTR;
                if (l_q.sh[0])
                begin
                  // Fetch the pointed register during the ack bit
                  l_d.rq_tgl  = ~l_q.rq_tgl;
                  l_d.word_ok = 1'b0;
                end
              end
              else
              begin
                l_d.st = L_IGNORE;
              end
            end
            else
            begin
              l_d.sda_drv = 1'b1;
              l_d.st      = L_ACK;
              unique case (l_q.idx)
                `ATI_IDX_PTR:
                begin
                  l_d.ptr    = l_q.sh;
                  l_d.ev     = '{wr: 1'b0, two: 1'b0, ptr: l_q.sh, data: 16'h0000};
                  l_d.ev_tgl = ~l_q.ev_tgl;
                  l_d.idx    = `ATI_IDX_UPPER;
                end
                `ATI_IDX_UPPER:
                begin
                  l_d.upper = l_q.sh;
                  l_d.half  = 1'b1;
                  l_d.idx   = `ATI_IDX_LOWER;
                end
                default:
                begin
                  l_d.ev     = '{wr: 1'b1, two: 1'b1, ptr: l_q.ptr, data: {l_q.upper, l_q.sh}};
                  l_d.ev_tgl = ~l_q.ev_tgl;
                  l_d.half   = 1'b0;
                  l_d.idx    = `ATI_IDX_UPPER;
                end
              endcase
            end
          end
        end
        L_ACK:
        begin
          if (scl_fall)
          begin
            l_d.sda_drv = 1'b0;
            if (l_q.rw)
            begin
              l_d = load_upper(l_d);
            end
            else
            begin
              l_d.st = L_RX;
            end
          end
        end
        L_WAIT:
        begin
          l_d = load_upper(l_d);
        end
        L_TX:
        begin
          if (scl_fall)
          begin
            if (l_q.cnt == `ATI_TX_LAST)
            begin
              l_d.sda_drv = 1'b0;
              l_d.st      = L_MACK;
            end
            else
            begin
              l_d.sh      = {l_q.sh[6:0], 1'b0};
              l_d.sda_drv = ~l_q.sh[6];
              l_d.cnt     = l_q.cnt + 4'h1;
            end
          end
        end
        L_MACK:
        begin
          if (scl_rise)
          begin
            l_d.ack_seen = ~l_q.sda_s2;
          end
          if (scl_fall)
          begin
            if (!l_q.ack_seen)
            begin
              l_d.st = L_IGNORE;
            end
            else if (l_q.tx_hi)
            begin
              l_d.sh      = l_q.word[7:0];
              l_d.sda_drv = ~l_q.word[7];
              l_d.cnt     = '0;
              l_d.tx_hi   = 1'b0;
              l_d.st      = L_TX;
              // Prefetch the next word while the lower byte goes out
              l_d.rq_tgl  = ~l_q.rq_tgl;
              l_d.word_ok = 1'b0;
            end
            else
            begin
              l_d = load_upper(l_d);
            end
          end
        end
      endcase
    end

    // Hold SCL low while waiting and one cycle after, so SDA settles first
    l_d.scl_hold = (l_d.st == L_WAIT) || (l_q.st == L_WAIT);

    // Reset keeps synchronisers running; strap is caught while reset holds
    if (!l_q.rst_s2)
    begin
      l_d          = '0;
      l_d.rst_s1   = resetn;
      l_d.rst_s2   = l_q.rst_s1;
      l_d.scl_s1   = scl_i;
      l_d.scl_s2   = l_q.scl_s1;
      l_d.scl_p    = l_q.scl_s2;
      l_d.sda_s1   = sda_i;
      l_d.sda_s2   = l_q.sda_s1;
      l_d.sda_p    = l_q.sda_s2;
      l_d.strap_s1 = addr_sel;
      l_d.strap_s2 = l_q.strap_s1;
      l_d.ak_s1    = s_q.ak_tgl;
      l_d.ak_s2    = l_q.ak_s1;
      l_d.ak_p     = l_q.ak_s2;
      l_d.st       = L_IDLE;
      l_d.ptr      = `ATI_PTR_RST;
      l_d.my_addr  = addr_of(l_q.strap_s2);
    end
  end

  always_ff @(posedge clk_link)
  begin
    l_q <= l_d;
  end

  // Open-drain pins: only ever pull low
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  assign sda_oe_n = ~l_q.sda_drv;
  assign scl_oe_n = ~l_q.scl_hold;

  // --------------------------------------------------------------------------
  // System domain: register-side events and word fetch
  // --------------------------------------------------------------------------

  // Next system state; guard swallows toggles while the link resets later
  always_comb
  begin
    s_d        = s_q;
    s_d.ev_s1  = l_q.ev_tgl;
    s_d.ev_s2  = s_q.ev_s1;
    s_d.ev_p   = s_q.ev_s2;
    s_d.rq_s1  = l_q.rq_tgl;
    s_d.rq_s2  = s_q.rq_s1;
    s_d.rq_p   = s_q.rq_s2;
    s_d.hs_s1  = l_q.hs;
    s_d.hs_s2  = s_q.hs_s1;
    s_d.wr_stb = 1'b0;
    s_d.rd_stb = 1'b0;
    if (!resetn)
    begin
      s_d.guard   = `ATI_GUARD_CYC;
      s_d.reg_ptr = `ATI_PTR_RST;
      s_d.wr_two  = 1'b0;
      s_d.wr_data = '0;
      s_d.rword   = '0;
      s_d.ak_tgl  = 1'b0;
    end
    else if (s_q.guard != '0)
    begin
      s_d.guard = s_q.guard - 5'h01;
    end
    else
    begin
      // Event payload has been held since well before its toggle arrived
      if (s_q.ev_s2 != s_q.ev_p)
      begin
        s_d.reg_ptr = l_q.ev.ptr;
        if (l_q.ev.wr)
        begin
          s_d.wr_stb  = 1'b1;
          s_d.wr_two  = l_q.ev.two;
          s_d.wr_data = l_q.ev.data;
        end
      end
      if (s_q.rq_s2 != s_q.rq_p)
      begin
        s_d.rword  = rd_word;
        s_d.rd_stb = 1'b1;
        s_d.ak_tgl = ~s_q.ak_tgl;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s_q <= s_d;
  end

  // User-side outputs, all from flops
  assign reg_ptr = s_q.reg_ptr;
  assign wr_stb  = s_q.wr_stb;
  assign wr_two  = s_q.wr_two;
  assign wr_data = s_q.wr_data;
  assign rd_stb  = s_q.rd_stb;
  assign hs_mode = s_q.hs_s2;

endmodule : ati_target

// [ati_defines.svh]
// Constants of the two-wire target interface
`ifndef ATI_DEFINES_SVH
`define ATI_DEFINES_SVH

// ----------------------------------------------------------------------------
// Target addresses
// ----------------------------------------------------------------------------
`define ATI_ADDR_FIXED   7'h54
`define ATI_ADDR_FLOAT   7'h50
`define ATI_ADDR_GND     7'h51
`define ATI_ADDR_SUPPLY  7'h52

// ----------------------------------------------------------------------------
// Strap pad comparator codes (mid-supply reports as float)
// ----------------------------------------------------------------------------
`define ATI_STRAP_GND    2'h0
`define ATI_STRAP_FLOAT  2'h1
`define ATI_STRAP_SUPPLY 2'h2

// ----------------------------------------------------------------------------
// Byte layout and counts
// ----------------------------------------------------------------------------
`define ATI_MCODE_TOP    5'h01
`define ATI_BITS_DONE    4'h8
`define ATI_TX_LAST      4'h7
`define ATI_IDX_PTR      2'h0
`define ATI_IDX_UPPER    2'h1
`define ATI_IDX_LOWER    2'h2
`define ATI_PTR_RST      8'h00
`define ATI_GUARD_CYC    5'h10

`endif

// [ati_pkg.sv]
// Types shared by the two-wire target interface
package ati_pkg;

  // Link protocol states
  typedef enum logic [2:0] {
    L_IDLE,
    L_ADDR,
    L_RX,
    L_ACK,
    L_TX,
    L_MACK,
    L_WAIT,
    L_IGNORE
  } ati_lstate_t;

  // Event handed from link domain to system domain
  typedef struct packed {
    logic        wr;
    logic        two;
    logic [7:0]  ptr;
    logic [15:0] data;
  } ati_ev_t;

  // All link-domain state
  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_p;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_p;
    logic [1:0]  strap_s1;
    logic [1:0]  strap_s2;
    logic        ak_s1;
    logic        ak_s2;
    logic        ak_p;
    logic [6:0]  my_addr;
    ati_lstate_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic [1:0]  idx;
    logic        half;
    logic        hs;
    logic [7:0]  ptr;
    logic [7:0]  upper;
    logic [15:0] word;
    logic        word_ok;
    logic        tx_hi;
    logic        ack_seen;
    logic        sda_drv;
    logic        scl_hold;
    ati_ev_t     ev;
    logic        ev_tgl;
    logic        rq_tgl;
  } ati_link_t;

  // All system-domain state
  typedef struct packed {
    logic        ev_s1;
    logic        ev_s2;
    logic        ev_p;
    logic        rq_s1;
    logic        rq_s2;
    logic        rq_p;
    logic        hs_s1;
    logic        hs_s2;
    logic [4:0]  guard;
    logic [7:0]  reg_ptr;
    logic        wr_stb;
    logic        wr_two;
    logic [15:0] wr_data;
    logic        rd_stb;
    logic [15:0] rword;
    logic        ak_tgl;
  } ati_sys_t;

endpackage : ati_pkg

// [ati_target_props.sv]
// Checker of the two-wire target's port behaviour
`timescale 1ns/1ps
module ati_target_props
  import ati_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        clk_link,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic [7:0]  reg_ptr,
  input wire logic        wr_stb,
  input wire logic        wr_two,
  input wire logic [15:0] wr_data,
  input wire logic        rd_stb,
  input wire logic        hs_mode
);
  // ----------------------------------------------------------------
  // Link side: the target only pulls low and never forges conditions
  // ----------------------------------------------------------------
  sequence s_drv_high;
    scl_i && !sda_oe_n;
  endsequence

  sequence s_stretch;
    $fell(scl_oe_n);
  endsequence

  pin_low_a: assert property (@(posedge clk_link) disable iff (!resetn)
    sda_o == 1'b0 && scl_o == 1'b0)
    else $error("open-drain level not low");
  sda_quiet_a: assert property (@(posedge clk_link) disable iff (!resetn)
    $changed(sda_oe_n) |-> !scl_i)
    else $error("target moved SDA while SCL high");
  sda_hold_a: assert property (@(posedge clk_link) disable iff (!resetn)
    s_drv_high |=> (!sda_oe_n || !scl_i))
    else $error("target dropped SDA inside a high phase");
  // Stretch must end once the word is in, or the bus hangs
  stretch_bound_a: assert property (@(posedge clk_link) disable iff (!resetn)
    s_stretch |-> ##[1:40] scl_oe_n)
    else $error("clock stretch too long");

  // ----------------------------------------------------------------
  // System side strobes and pointer
  // ----------------------------------------------------------------
  wr_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_stb |=> !wr_stb [*8])
    else $error("write strobe too long or too close");
  rd_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_stb |=> !rd_stb [*8])
    else $error("read strobe too long or too close");
  wr_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $changed({wr_two, wr_data}) |-> wr_stb)
    else $error("write data moved without strobe");
  ptr_still_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $changed(reg_ptr) |-> !rd_stb && !wr_stb)
    else $error("pointer moved during an access");
  hs_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(hs_mode) |=> hs_mode [*8])
    else $error("high speed mode dropped early");
endmodule : ati_target_props

bind ati_target ati_target_props ati_target_props_i (
  .clk_sys (clk_sys),
  .resetn  (resetn),
  .clk_link(clk_link),
  .scl_i   (scl_i),
  .scl_o   (scl_o),
  .scl_oe_n(scl_oe_n),
  .sda_o   (sda_o),
  .sda_oe_n(sda_oe_n),
  .reg_ptr (reg_ptr),
  .wr_stb  (wr_stb),
  .wr_two  (wr_two),
  .wr_data (wr_data),
  .rd_stb  (rd_stb),
  .hs_mode (hs_mode)
);

// [ati_ctl.sv]
// Behavioural two-wire bus controller facing the target
`timescale 1ns/1ps
module ati_ctl (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rel,
  output logic      sda_rel
);
  int q = 400;  // Quarter bit in ns; keeps each phase above 3 link periods

  // Bus idle: both lines released to the pull-ups
  initial
  begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end

  // Release SCL and wait out a stretch, bounded so a stuck target shows
  task automatic scl_up;
    int n;
    n = 0;
    scl_rel = 1'b1;
    while (scl !== 1'b1 && n < 500)
    begin
      #20;
      n++;
    end
  endtask : scl_up

  // One bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic v, output logic s);
    sda_rel = v;
    #(q);
    scl_up();
    #(q);
    s = sda;
    #(q);
    scl_rel = 1'b0;
    #(q);
  endtask : bit_io

  // Start or repeated start: SDA falls while SCL high
  task automatic start_c;
    sda_rel = 1'b1;
    #(q);
    scl_up();
    #(q);
    sda_rel = 1'b0;
    #(q);
    scl_rel = 1'b0;
    #(q);
  endtask : start_c

  // Stop: SDA rises while SCL high
  task automatic stop_c;
    sda_rel = 1'b0;
    #(q);
    scl_up();
    #(q);
    sda_rel = 1'b1;
    #(2*q);
  endtask : stop_c

  // Byte out MSB first, then SDA released for the target's answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // Byte in; acknowledge only when more is wanted
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~more, s);
  endtask : rbyte
endmodule : ati_ctl

// [ati_target_tb.sv]
// Self-checking bench of the two-wire target
`timescale 1ns/1ps
`include "ati_defines.svh"
module ati_target_tb
  import ati_pkg::*;
;
  logic        clk_sys  = 1'b0;
  logic        clk_link = 1'b0;
  logic        resetn   = 1'b0;
  logic [1:0]  addr_sel = `ATI_STRAP_FLOAT;
  logic [15:0] rd_word  = 16'h0000;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, scl_rel, sda_rel;
  logic        wr_stb, wr_two, rd_stb, hs_mode;
  logic [7:0]  reg_ptr, p, b;
  logic [15:0] wr_data, w;
  logic [6:0]  me;
  wire         scl_w = scl_rel & (scl_oe_n | scl_o);
  wire         sda_w = sda_rel & (sda_oe_n | sda_o);
  int          failures, cmp_count, cyc, rd_cnt;
  integer      seed = 32'h5b8abac9;
  logic [15:0] regs [256];
  logic [16:0] exp_q [$];
  logic [1:0]  codes [3] = '{`ATI_STRAP_GND, `ATI_STRAP_SUPPLY, 2'h3};
  logic [6:0]  adrs [3]  = '{`ATI_ADDR_GND, `ATI_ADDR_SUPPLY, `ATI_ADDR_FLOAT};

  // ----------------------------------------------------------------
  // Clocks, instances and register file model
  // ----------------------------------------------------------------
  always #12.5 clk_sys = ~clk_sys;
  // Odd offset keeps link edges apart from system edges
  initial
  begin
    #7.3;
    forever #40 clk_link = ~clk_link;
  end
  always @(posedge clk_sys)
    rd_word <= regs[reg_ptr];

  ati_target #(.STRAPPED(1)) ati_target_i (.clk_sys(clk_sys), .resetn(resetn),
    .clk_link(clk_link), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
    .reg_ptr(reg_ptr), .wr_stb(wr_stb), .wr_two(wr_two), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_word(rd_word), .hs_mode(hs_mode));
  ati_ctl ati_ctl_i (.scl(scl_w), .sda(sda_w), .scl_rel(scl_rel), .sda_rel(sda_rel));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // Strap is captured while held in reset; then guard plus idle time
  task automatic reset_dut(input logic [1:0] code);
    @(posedge clk_sys);
    resetn   <= 1'b0;
    addr_sel <= code;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (60) @(posedge clk_sys);
    #3;
  endtask : reset_dut

  task automatic wb(input logic [7:0] v, input logic exp_ack);
    logic a;
    ati_ctl_i.wbyte(v, a);
    check("byte ack", {31'h0, a}, {31'h0, exp_ack});
  endtask : wb

  task automatic rb(input logic more, input logic [7:0] exp);
    logic [7:0] got;
    ati_ctl_i.rbyte(more, got);
    check("read byte", {24'h0, got}, {24'h0, exp});
  endtask : rb

  task automatic addr(input logic [6:0] a, input logic rd, input logic exp_ack);
    ati_ctl_i.start_c();
    wb({a, rd}, exp_ack);
  endtask : addr

  task automatic hs_is(input string what, input logic v);
    repeat (20) @(posedge clk_sys);
    #3;
    check(what, {31'h0, hs_mode}, {31'h0, v});
  endtask : hs_is

  // ----------------------------------------------------------------
  // Result watcher and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (resetn === 1'b1 && wr_stb === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray write", 32'h1, 32'h0);
      else
        check("write", {15'h0, wr_two, wr_data}, {15'h0, exp_q.pop_front()});
    end
  end

  // Word fetches seen on the register side, one per word plus the prefetch
  always @(posedge clk_sys)
  begin
    if (resetn === 1'b1 && rd_stb === 1'b1)
      rd_cnt++;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      $display("Error run length expected end seen hang");
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    foreach (regs[i])
      regs[i] = 16'($random(seed));
    reset_dut(`ATI_STRAP_FLOAT);
    me = `ATI_ADDR_FLOAT;
    p  = 8'($random(seed));
    addr(me, 1'b0, 1'b1);
    wb(p, 1'b1);
    repeat (2)
    begin
      w = 16'($random(seed));
      exp_q.push_back({1'b1, w});
      wb(w[15:8], 1'b1);
      wb(w[7:0], 1'b1);
    end
    ati_ctl_i.stop_c();
    check("pointer", {24'h0, reg_ptr}, {24'h0, p});
    $display("Word writes done");
    p = 8'($random(seed));
    b = 8'($random(seed));
    addr(me, 1'b0, 1'b1);
    wb(p, 1'b1);
    exp_q.push_back({1'b0, b, 8'h00});
    wb(b, 1'b1);
    ati_ctl_i.stop_c();
    $display("Single byte write done");
    addr(me, 1'b1, 1'b1);
    for (int k = 0; k < 6; k++)
      rb(k < 5, k[0] ? regs[p][7:0] : regs[p][15:8]);
    ati_ctl_i.stop_c();
    check("read fetches", rd_cnt, 32'h4);
    $display("Streamed read done");
    p = 8'($random(seed));
    addr(me, 1'b0, 1'b1);
    wb(p, 1'b1);
    addr(me, 1'b1, 1'b1);
    rb(1'b0, regs[p][15:8]);
    ati_ctl_i.stop_c();
    check("pointer read fetch", rd_cnt, 32'h5);
    $display("Pointer then read done");
    addr(`ATI_ADDR_FIXED, 1'b0, 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h5a, 1'b0);
    ati_ctl_i.stop_c();
    $display("Foreign address done");
    ati_ctl_i.start_c();
    wb(8'h0b, 1'b0);
    hs_is("hs entry", 1'b1);
    ati_ctl_i.q = 300;
    p = 8'($random(seed));
    w = 16'($random(seed));
    addr(me, 1'b0, 1'b1);
    wb(p, 1'b1);
    exp_q.push_back({1'b1, w});
    wb(w[15:8], 1'b1);
    wb(w[7:0], 1'b1);
    addr(me, 1'b1, 1'b1);
    check("hs kept", {31'h0, hs_mode}, 32'h1);
    rb(1'b0, regs[p][15:8]);
    ati_ctl_i.stop_c();
    ati_ctl_i.q = 400;
    hs_is("hs left", 1'b0);
    $display("High speed done");
    for (int k = 0; k < 3; k++)
    begin
      reset_dut(codes[k]);
      addr(adrs[k], 1'b0, 1'b1);
      ati_ctl_i.stop_c();
      addr(`ATI_ADDR_FIXED, 1'b0, 1'b0);
      ati_ctl_i.stop_c();
    end
    $display("Strap addresses done");
    check("pending writes", exp_q.size(), 32'h0);
    finish_test();
  end
endmodule : ati_target_tb
